// >>> gate_logic_pkg.sv
package gate_logic_pkg;

  // ==========================================================
  // Timing
  localparam int PCLK_HZ         = 20_000_000;
  localparam int PCLK_PERIOD_NS  = 50;
  localparam int OSC_NOM_HZ      = 9_000_000;
  localparam int OSC_TOL_PCT     = 30;
  localparam int RATE_UNIT_HZ    = 100_000;
  localparam int DEAD_TICKS      = 3;
  localparam int TENTH_US_NS     = 100;
  localparam int TENTH_US_CYCLES =
    (TENTH_US_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  // Tick accumulator wraps at the clock rate in rate units
  localparam logic [7:0] ACC_WRAP = 8'(PCLK_HZ / RATE_UNIT_HZ);
  localparam logic [7:0] STEP_NOM = 8'(OSC_NOM_HZ / RATE_UNIT_HZ);
  localparam logic [7:0] STEP_MIN =
    8'(OSC_NOM_HZ / 100 * (100 - OSC_TOL_PCT) / RATE_UNIT_HZ);
  localparam logic [7:0] STEP_MAX =
    8'(OSC_NOM_HZ / 100 * (100 + OSC_TOL_PCT) / RATE_UNIT_HZ);
  localparam logic [1:0] DEAD_CNT   = 2'(DEAD_TICKS);
  localparam logic [1:0] TENTH_LAST = 2'(TENTH_US_CYCLES - 1);

  // ==========================================================
  // Register offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] OSC_STEP_OFS = 8'h04;
  localparam logic [7:0] OC_QUAL_OFS  = 8'h08;
  localparam logic [7:0] RCAP_OFS     = 8'h0c;
  localparam logic [7:0] STATUS_OFS   = 8'h10;
  localparam logic [7:0] EVENTS_OFS   = 8'h14;

  // ==========================================================
  // Fields and reset values
  localparam int CTRL_EN_BIT  = 0;
  localparam int ST_THERM_BIT = 0;
  localparam int ST_OC_BIT    = 1;
  localparam int ST_VM_BIT    = 2;
  localparam int ST_REG_BIT   = 3;
  localparam int ST_OFF_BIT   = 4;
  localparam int ST_PHASE_LSB = 8;
  localparam logic        CTRL_EN_RST  = 1'b1;
  localparam logic [15:0] OC_QUAL_RST  = 16'h0009;
  localparam logic [15:0] RCAP_RST     = 16'h03e8;

  // ==========================================================
  // Synchroniser lanes
  localparam int SYNC_W    = 15;
  localparam int CMD_LSB   = 0;
  localparam int OC_LSB    = 6;
  localparam int THERM_IDX = 12;
  localparam int VM_IDX    = 13;
  localparam int REG_IDX   = 14;

  typedef enum logic [1:0] {OC_RUN, OC_QUALIFY, OC_OFF} oc_state_t;

  // Command pair to {high switch, low switch}; equal commands give off
  function automatic logic [1:0] drive_decode(input logic hi,
                                              input logic lo);
    drive_decode = {hi & ~lo, lo & ~hi};
  endfunction

endpackage

// >>> phase_channel.sv
`timescale 1ns/1ps
module phase_channel
  import gate_logic_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Timing and protection
  input  wire logic osc_tick,
  input  wire logic force_off,
  // Filtered commands
  input  wire logic high_cmd,
  input  wire logic low_cmd,
  // Switch enables, both low means high impedance
  output logic      high_sw_en,
  output logic      low_sw_en
);

  logic       high_prev_reg;
  logic       low_prev_reg;
  logic [1:0] wait_reg;
  logic [1:0] wait_next;
  logic       high_en_reg;
  logic       low_en_reg;
  logic [1:0] target;
  logic       rise;
  logic       apply;

  // ==========================================================
  // Decode and edge detection
  // truth table
  assign target = drive_decode(high_cmd, low_cmd);
  assign rise   = (high_cmd & ~high_prev_reg) | (low_cmd & ~low_prev_reg);
  // tick aligned; a pending dead time blocks earlier updates
  assign apply  = osc_tick & ~rise & (wait_reg <= 2'd1);

  // dead time, a new rise restarts the count
  always_comb begin
    if (force_off) begin
      wait_next = 2'd0;
    end else if (rise) begin
      wait_next = DEAD_CNT;
    end else if (osc_tick && wait_reg != 2'd0) begin
      wait_next = wait_reg - 2'd1;
    end else begin
      wait_next = wait_reg;
    end
  end

  // Previous commands and wait counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_prev_reg <= 1'b0;
      low_prev_reg  <= 1'b0;
      wait_reg      <= 2'd0;
    end else begin
      high_prev_reg <= high_cmd;
      low_prev_reg  <= low_cmd;
      wait_reg      <= wait_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_en_reg <= 1'b0;
      low_en_reg  <= 1'b0;
    end else if (force_off) begin
      high_en_reg <= 1'b0;
      low_en_reg  <= 1'b0;
    end else if (apply) begin
      high_en_reg <= target[1];
      low_en_reg  <= target[0];
    end
  end

  assign high_sw_en = high_en_reg;
  assign low_sw_en  = low_en_reg;

endmodule

// >>> half_bridge_logic.sv
`timescale 1ns/1ps
// Notes on behaviour
// - High-only drives high, low-only drives low, equal commands float
// - Each phase decodes its own command pair only
// - Command changes take effect on internal tick edges only; a forced off acts on the next clock edge
// - A rising command waits three ticks before the output moves
// - Internal tick runs near 9 MHz, trimmable within thirty percent
// - Thermal shutdown floats all outputs until the flag clears
// - Thermal shutdown pulls the thermal flag pin low
// - Overcurrent shutdown pulls the overcurrent flag pin low
// - Motor supply low floats all outputs, recovers automatically
// - Regulator rail low floats all outputs, recovers automatically
// - Overcurrent on any switch for qualification time floats everything
// - After overcurrent, outputs stay off for capacitor-scaled restart term
module half_bridge_logic
  import gate_logic_pkg::*;
#(
  parameter int unsigned RESTART_TENTH_US_PER_NF = 98595
)(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Phase commands from the motor controller
  input  wire logic        phase_a_high_cmd,
  input  wire logic        phase_a_low_cmd,
  input  wire logic        phase_b_high_cmd,
  input  wire logic        phase_b_low_cmd,
  input  wire logic        phase_c_high_cmd,
  input  wire logic        phase_c_low_cmd,
  // Protection detector flags
  input  wire logic [5:0]  overcurrent_sense,
  input  wire logic        thermal_shutdown,
  input  wire logic        supply_low_lockout,
  input  wire logic        regulator_low_lockout,
  // Power switch enables
  output logic             phase_a_high_en,
  output logic             phase_a_low_en,
  output logic             phase_b_high_en,
  output logic             phase_b_low_en,
  output logic             phase_c_high_en,
  output logic             phase_c_low_en,
  // Open-drain flag pins, enable active low
  output logic             thermal_flag_pin_o,
  output logic             thermal_flag_pin_oe_n,
  output logic             overcurrent_flag_pin_o,
  output logic             overcurrent_flag_pin_oe_n
);

  import gate_logic_pkg::*;

  // ==========================================================
  // Declarations
  logic [SYNC_W-1:0] s1_reg;
  logic [SYNC_W-1:0] s2_reg;
  logic [SYNC_W-1:0] s3_reg;
  logic [SYNC_W-1:0] filt_reg;
  logic [SYNC_W-1:0] filt_next;
  logic [SYNC_W-1:0] raw_in;

  logic [7:0]  acc_reg;
  logic [7:0]  acc_next;
  logic [8:0]  acc_sum;
  logic        tick_reg;
  logic        tick_next;

  oc_state_t   oc_state_reg;
  oc_state_t   oc_state_next;
  logic [15:0] qual_cnt_reg;
  logic [15:0] qual_cnt_next;
  logic [1:0]  tenth_reg;
  logic [1:0]  tenth_next;
  logic [39:0] restart_cnt_reg;
  logic [39:0] restart_cnt_next;
  logic [39:0] restart_term;
  logic        oc_any;
  logic        tenth_tick;

  logic        thermal_live;
  logic        vm_low_live;
  logic        reg_low_live;
  logic        oc_off_live;
  logic        force_off_reg;
  logic        force_off_next;
  logic [3:0]  cond_now;
  logic [3:0]  cond_prev_reg;
  logic [3:0]  ev_reg;
  logic [3:0]  ev_next;

  logic        ctrl_en_reg;
  logic [7:0]  osc_step_reg;
  logic [15:0] oc_qual_reg;
  logic [15:0] restart_cap_reg;
  logic [7:0]  step_clamped;
  logic [31:0] status_word;
  logic [31:0] rdata;
  logic        setup;
  logic        mapped;
  logic        wr;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        therm_flag_reg;
  logic        oc_flag_reg;

  // ==========================================================
  // Input synchronisers
  assign raw_in = {regulator_low_lockout, supply_low_lockout,
                   thermal_shutdown, overcurrent_sense,
                   phase_c_low_cmd, phase_c_high_cmd,
                   phase_b_low_cmd, phase_b_high_cmd,
                   phase_a_low_cmd, phase_a_high_cmd};

  // A lane moves only once the second and third stages agree
  assign filt_next = (s2_reg & ~(s2_reg ^ s3_reg))
                   | (filt_reg & (s2_reg ^ s3_reg));

  // three-stage capture of every external flag and command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg   <= raw_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  assign thermal_live = filt_reg[THERM_IDX];
  assign vm_low_live  = filt_reg[VM_IDX];
  assign reg_low_live = filt_reg[REG_IDX];
  assign oc_any       = |filt_reg[OC_LSB +: 6];

  // ==========================================================
  // Internal tick source
  // Fractional accumulator: average tick rate is step/wrap of pclk,
  // so a 20 MHz clock yields 9 MHz mean with some period jitter.
  // nominal rate and trim
  assign acc_sum   = {1'b0, acc_reg} + {1'b0, osc_step_reg};
  assign tick_next = (acc_sum >= {1'b0, ACC_WRAP});
  assign acc_next  = tick_next ? 8'(acc_sum - {1'b0, ACC_WRAP})
                               : acc_sum[7:0];

  // Accumulator and tick pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      acc_reg  <= acc_next;
      tick_reg <= tick_next;
    end
  end

  // ==========================================================
  // Overcurrent qualification and restart
  assign tenth_tick   = (tenth_reg == TENTH_LAST);
  assign tenth_next   = tenth_tick ? 2'd0 : tenth_reg + 2'd1;
  assign restart_term = 40'(restart_cap_reg)
                      * 40'(RESTART_TENTH_US_PER_NF);

  // qualify, shut down, then wait out the restart term
  always_comb begin
    oc_state_next    = oc_state_reg;
    qual_cnt_next    = qual_cnt_reg;
    restart_cnt_next = restart_cnt_reg;
    case (oc_state_reg)
      OC_RUN: begin
        qual_cnt_next = 16'h0000;
        if (oc_any) begin
          oc_state_next = OC_QUALIFY;
        end
      end
      OC_QUALIFY: begin
        if (!oc_any) begin
          oc_state_next = OC_RUN;
        end else if (tick_reg) begin
          if (qual_cnt_reg + 16'h0001 >= oc_qual_reg) begin
            oc_state_next    = OC_OFF;
            restart_cnt_next = 40'h0;
          end else begin
            qual_cnt_next = qual_cnt_reg + 16'h0001;
          end
        end
      end
      OC_OFF: begin
        if (restart_cnt_reg >= restart_term) begin
          oc_state_next = OC_RUN;
        end else if (tenth_tick) begin
          restart_cnt_next = restart_cnt_reg + 40'h1;
        end
      end
      default: begin
        oc_state_next = OC_RUN;
      end
    endcase
  end

  // Qualification and restart state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_state_reg    <= OC_RUN;
      qual_cnt_reg    <= 16'h0000;
      restart_cnt_reg <= 40'h0;
      tenth_reg       <= 2'd0;
    end else begin
      oc_state_reg    <= oc_state_next;
      qual_cnt_reg    <= qual_cnt_next;
      restart_cnt_reg <= restart_cnt_next;
      tenth_reg       <= tenth_next;
    end
  end

  assign oc_off_live = (oc_state_reg == OC_OFF);

  // ==========================================================
  // Protection combine and events
  // any active condition forces every phase off
  assign force_off_next = thermal_live | vm_low_live | reg_low_live
                        | oc_off_live | ~ctrl_en_reg;
  assign cond_now = {reg_low_live, vm_low_live, oc_off_live, thermal_live};
  // Sticky on rising condition; a new event beats a same-cycle clear
  assign ev_next  = (ev_reg & ~((wr && paddr == EVENTS_OFS)
                                ? pwdata[3:0] : 4'h0))
                  | (cond_now & ~cond_prev_reg);

  // Forced-off level, events and flag pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_off_reg  <= 1'b1;
      cond_prev_reg  <= 4'h0;
      ev_reg         <= 4'h0;
      therm_flag_reg <= 1'b0;
      oc_flag_reg    <= 1'b0;
    end else begin
      force_off_reg  <= force_off_next;
      cond_prev_reg  <= cond_now;
      ev_reg         <= ev_next;
      // thermal flag follows the shutdown state
      therm_flag_reg <= thermal_live;
      // overcurrent flag follows the shutdown state
      oc_flag_reg    <= oc_off_live;
    end
  end

  // Pins only ever pull low; an external pull-up gives the high level
  assign thermal_flag_pin_o        = 1'b0;
  assign thermal_flag_pin_oe_n     = ~therm_flag_reg;
  assign overcurrent_flag_pin_o    = 1'b0;
  assign overcurrent_flag_pin_oe_n = ~oc_flag_reg;

  // ==========================================================
  // Phase channels
  // three independent channels, each sees only its own pair
  phase_channel u_phase_a (
    .pclk       (pclk),
    .presetn    (presetn),
    .osc_tick   (tick_reg),
    .force_off  (force_off_reg),
    .high_cmd   (filt_reg[CMD_LSB + 0]),
    .low_cmd    (filt_reg[CMD_LSB + 1]),
    .high_sw_en (phase_a_high_en),
    .low_sw_en  (phase_a_low_en)
  );

  phase_channel u_phase_b (
    .pclk       (pclk),
    .presetn    (presetn),
    .osc_tick   (tick_reg),
    .force_off  (force_off_reg),
    .high_cmd   (filt_reg[CMD_LSB + 2]),
    .low_cmd    (filt_reg[CMD_LSB + 3]),
    .high_sw_en (phase_b_high_en),
    .low_sw_en  (phase_b_low_en)
  );

  phase_channel u_phase_c (
    .pclk       (pclk),
    .presetn    (presetn),
    .osc_tick   (tick_reg),
    .force_off  (force_off_reg),
    .high_cmd   (filt_reg[CMD_LSB + 4]),
    .low_cmd    (filt_reg[CMD_LSB + 5]),
    .high_sw_en (phase_c_high_en),
    .low_sw_en  (phase_c_low_en)
  );

  // ==========================================================
  // APB register file
  // One wait-free access cycle: data is captured in setup, so the
  // access phase always completes on its first edge.
  assign setup  = psel & ~penable;
  assign mapped = (paddr == CTRL_OFS) | (paddr == OSC_STEP_OFS)
                | (paddr == OC_QUAL_OFS) | (paddr == RCAP_OFS)
                | (paddr == STATUS_OFS) | (paddr == EVENTS_OFS);
  assign wr     = psel & penable & pready_reg & pwrite & ~pslverr_reg;

  // writes outside the tolerance band are clamped to its edge
  assign step_clamped = (pwdata[7:0] < STEP_MIN) ? STEP_MIN
                      : (pwdata[7:0] > STEP_MAX) ? STEP_MAX
                      : pwdata[7:0];

  assign status_word = {18'h0,
                        phase_c_low_en, phase_c_high_en,
                        phase_b_low_en, phase_b_high_en,
                        phase_a_low_en, phase_a_high_en,
                        3'h0, force_off_reg,
                        reg_low_live, vm_low_live,
                        oc_off_live, thermal_live};

  // Read selection, unmapped reads return zero
  assign rdata = (paddr == CTRL_OFS)     ? {31'h0, ctrl_en_reg}
               : (paddr == OSC_STEP_OFS) ? {24'h0, osc_step_reg}
               : (paddr == OC_QUAL_OFS)  ? {16'h0, oc_qual_reg}
               : (paddr == RCAP_OFS)     ? {16'h0, restart_cap_reg}
               : (paddr == STATUS_OFS)   ? status_word
               : (paddr == EVENTS_OFS)   ? {28'h0, ev_reg}
               : 32'h0;

  // Bus handshake and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata_reg <= rdata;
      end
    end
  end

  // Writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_reg     <= CTRL_EN_RST;
      osc_step_reg    <= STEP_NOM;
      oc_qual_reg     <= OC_QUAL_RST;
      restart_cap_reg <= RCAP_RST;
    end else if (wr) begin
      if (paddr == CTRL_OFS) begin
        ctrl_en_reg <= pwdata[CTRL_EN_BIT];
      end
      if (paddr == OSC_STEP_OFS) begin
        osc_step_reg <= step_clamped;
      end
      if (paddr == OC_QUAL_OFS) begin
        oc_qual_reg <= pwdata[15:0];
      end
      if (paddr == RCAP_OFS) begin
        restart_cap_reg <= pwdata[15:0];
      end
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

endmodule

// >>> half_bridge_logic_props.sv
`timescale 1ns/1ps
// ==========================================================
// Handshake and protection checks on the bridge logic pins
module half_bridge_logic_props (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // APB handshake
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Commands and detector flags
  input wire logic       phase_a_high_cmd,
  input wire logic       phase_a_low_cmd,
  input wire logic [5:0] overcurrent_sense,
  input wire logic       thermal_shutdown,
  input wire logic       supply_low_lockout,
  input wire logic       regulator_low_lockout,
  // Switch enables and flag pins
  input wire logic       phase_a_high_en,
  input wire logic       phase_a_low_en,
  input wire logic       phase_b_high_en,
  input wire logic       phase_b_low_en,
  input wire logic       phase_c_high_en,
  input wire logic       phase_c_low_en,
  input wire logic       thermal_flag_pin_o,
  input wire logic       thermal_flag_pin_oe_n,
  input wire logic       overcurrent_flag_pin_oe_n
);
  // Phase a held high with no detector active, and all-off view
  wire run_ok = phase_a_high_cmd & ~phase_a_low_cmd & ~thermal_shutdown
              & ~supply_low_lockout & ~regulator_low_lockout
              & ~|overcurrent_sense & overcurrent_flag_pin_oe_n;
  wire all_off = ~|{phase_a_high_en, phase_a_low_en, phase_b_high_en,
                    phase_b_low_en, phase_c_high_en, phase_c_low_en};
  logic [5:0] run_cnt;
  logic [5:0] oc_cnt;

  // Saturating counters keep the check live while a condition holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt <= 6'h00;
      oc_cnt  <= 6'h00;
    end else begin
      run_cnt <= !run_ok ? 6'h00 : run_cnt + 6'(run_cnt != 6'h18);
      oc_cnt  <= ~|overcurrent_sense ? 6'h00 : oc_cnt + 6'(oc_cnt != 6'h22);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_no_cross: assert property (
    !(phase_a_high_en && phase_a_low_en) && !(phase_b_high_en &&
    phase_b_low_en) && !(phase_c_high_en && phase_c_low_en))
    else $error("high and low switch enabled together");
  chk_rise_wait: assert property (
    $rose(phase_a_high_cmd) && !phase_a_low_cmd && !phase_a_high_en
    |-> !phase_a_high_en [*5])
    else $error("high switch moved before dead time");
  chk_drive_high: assert property (run_cnt == 6'h18 |-> phase_a_high_en)
    else $error("high command not applied in time");
  chk_therm_off: assert property (thermal_shutdown [*8] |-> all_off)
    else $error("outputs driven during thermal shutdown");
  chk_supply_off: assert property (supply_low_lockout [*8] |-> all_off)
    else $error("outputs driven with motor supply low");
  chk_rail_off: assert property (regulator_low_lockout [*8] |-> all_off)
    else $error("outputs driven with regulator rail low");
  chk_therm_flag: assert property (
    thermal_shutdown [*8] |-> !thermal_flag_pin_oe_n && !thermal_flag_pin_o)
    else $error("thermal flag pin not pulled low");
  chk_therm_clear: assert property (
    !thermal_shutdown [*8] |-> thermal_flag_pin_oe_n)
    else $error("thermal flag pin low without event");
  chk_oc_flag: assert property (
    oc_cnt == 6'h22 |-> !overcurrent_flag_pin_oe_n)
    else $error("overcurrent not flagged after qualification");
  chk_oc_off: assert property (!overcurrent_flag_pin_oe_n [*3] |-> all_off)
    else $error("outputs driven during overcurrent shutdown");
  chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");

  // Main scenarios reached
  cov_run: cover property (run_cnt == 6'h18);
  cov_oc: cover property (oc_cnt == 6'h22);
  cov_therm: cover property (!thermal_flag_pin_oe_n);
  cov_err: cover property (pslverr);
endmodule

// >>> motor_ctrl_model.sv
`timescale 1ns/1ps
// ==========================================================
// Motor controller stand-in: drives the six commands as levels
module motor_ctrl_model (
  // Clock
  input  wire logic       pclk,
  // Requested pattern and pacing
  input  wire logic [5:0] cmd_req,
  input  wire logic       slow,
  // Command pins, bit 2n high side and 2n+1 low side of phase n
  output logic [5:0]      cmd = 6'h00
);
  logic [5:0] stage_reg = 6'h00;
  // Slow mode adds a cycle of lag, as a busy controller would
  always @(posedge pclk) begin
    stage_reg <= cmd_req;
    cmd       <= slow ? stage_reg : cmd_req;
  end
endmodule

// >>> half_bridge_logic_tb.sv
`timescale 1ns/1ps
module half_bridge_logic_tb;
  import gate_logic_pkg::*;
  // ==========================================================
  // Signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  cmd_req, cmd, en, sense, pat;
  logic        slow, therm, vlow, rlow, t_o, t_oe_n, o_o, o_oe_n;
  int          fails, n_tests, seed, lat_r, lat_f;
  logic [7:0]  ofs [5] = '{CTRL_OFS, OSC_STEP_OFS, OC_QUAL_OFS, RCAP_OFS,
                           8'h18};
  logic [31:0] rst [5] = '{32'(CTRL_EN_RST), 32'(STEP_NOM),
                           32'(OC_QUAL_RST), 32'(RCAP_RST), 32'h0};
  logic [5:0]  corner [5] = '{6'h00, 6'h15, 6'h2a, 6'h3f, 6'h09};

  motor_ctrl_model motor_ctrl_model_inst (
    .pclk(pclk), .cmd_req(cmd_req), .slow(slow), .cmd(cmd));
  // Restart unit of one per nF keeps the restart term short
  half_bridge_logic #(.RESTART_TENTH_US_PER_NF(1)) half_bridge_logic_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .phase_a_high_cmd(cmd[0]), .phase_a_low_cmd(cmd[1]),
    .phase_b_high_cmd(cmd[2]), .phase_b_low_cmd(cmd[3]),
    .phase_c_high_cmd(cmd[4]), .phase_c_low_cmd(cmd[5]),
    .overcurrent_sense(sense), .thermal_shutdown(therm),
    .supply_low_lockout(vlow), .regulator_low_lockout(rlow),
    .phase_a_high_en(en[0]), .phase_a_low_en(en[1]),
    .phase_b_high_en(en[2]), .phase_b_low_en(en[3]),
    .phase_c_high_en(en[4]), .phase_c_low_en(en[5]),
    .thermal_flag_pin_o(t_o), .thermal_flag_pin_oe_n(t_oe_n),
    .overcurrent_flag_pin_o(o_o), .overcurrent_flag_pin_oe_n(o_oe_n));

  // Clock at 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [5:0] exp_en(input logic [5:0] c);
    logic [5:0] e;
    for (int i = 0; i < 6; i += 2) begin
      e[i]   = c[i] & ~c[i+1];
      e[i+1] = c[i+1] & ~c[i];
    end
    return e;
  endfunction

  task automatic check(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer; holds the request until ready, then a idle edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k = 0;
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      $display("MISMATCH %0t no ready", $time);
      complete_run();
    end
    @(posedge pclk);
  endtask

  // Edges until phase a high switch reaches v, bounded
  task automatic wait_a(input logic v, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (en[0] !== v && n < 60);
    if (en[0] !== v) begin
      fails++;
      $display("MISMATCH %0t no output change", $time);
      complete_run();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    seed = 82351;
    fails = 0;
    n_tests = 0;
    {presetn, psel, penable, pwrite, slow, therm, vlow, rlow} = 8'h00;
    {paddr, pwdata, cmd_req, sense} = '0;
    repeat (3) @(posedge pclk);
    check({en, t_oe_n, o_oe_n}, 8'h03, "reset outputs");
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      check(rd, rst[i], "reset value");
      check(err, i == 4, "slave error");
    end
    // Rate writes below the band land on its lower edge
    apb(1'b1, OSC_STEP_OFS, 32'h0);
    apb(1'b0, OSC_STEP_OFS, 32'h0);
    check(rd, 32'(STEP_MIN), "step clamp");
    apb(1'b1, OSC_STEP_OFS, 32'(STEP_NOM));
    apb(1'b1, RCAP_OFS, 32'h14);
    // Truth table corners, then random patterns, at both paces
    for (int i = 0; i < 30; i++) begin
      pat = (i < 5) ? corner[i] : 6'($random(seed));
      cmd_req <= pat;
      slow    <= i[0];
      repeat (30) @(posedge pclk);
      check(en, exp_en(pat), "phase decode");
      apb(1'b0, STATUS_OFS, 32'h0);
      check(rd[13:8], exp_en(pat), "status phases");
    end
    // Rise waits out dead time, fall does not
    slow    <= 1'b0;
    cmd_req <= 6'h00;
    repeat (30) @(posedge pclk);
    cmd_req <= 6'h01;
    wait_a(1'b1, lat_r);
    cmd_req <= 6'h00;
    wait_a(1'b0, lat_f);
    check(lat_r >= 8 && lat_r < 30, 1'b1, "rise latency");
    check(lat_r > lat_f + 2, 1'b1, "fall faster");
    // Drive enable cleared floats every phase until set again
    cmd_req <= 6'h18;
    apb(1'b1, CTRL_OFS, 32'h0);
    repeat (30) @(posedge pclk);
    check(en, 6'h00, "drive disabled");
    apb(1'b1, CTRL_OFS, 32'h1);
    repeat (30) @(posedge pclk);
    check(en, exp_en(6'h18), "drive enabled");
    // Each supply or thermal detector floats all, then recovery
    cmd_req <= 6'h19;
    for (int p = 0; p < 3; p++) begin
      {rlow, vlow, therm} <= 3'(1 << p);
      repeat (12) @(posedge pclk);
      check(en, 6'h00, "forced off");
      check({t_o, t_oe_n}, {1'b0, p != 0}, "thermal flag");
      {rlow, vlow, therm} <= 3'h0;
      repeat (30) @(posedge pclk);
      check(en, exp_en(6'h19), "recovered");
    end
    // Sticky events of the three detectors, then cleared by a write
    apb(1'b0, EVENTS_OFS, 32'h0);
    check(rd, 32'hd, "events");
    apb(1'b1, EVENTS_OFS, 32'hf);
    // Short overcurrent is not qualified
    sense <= 6'h08;
    repeat (8) @(posedge pclk);
    sense <= 6'h00;
    repeat (30) @(posedge pclk);
    check({o_oe_n, en}, {1'b1, exp_en(6'h19)}, "short pulse");
    // Qualified overcurrent on every switch, restart term then resume
    for (int s = 0; s < 6; s++) begin
      sense <= 6'(1 << s);
      repeat (44) @(posedge pclk);
      sense <= 6'h00;
      check({o_o, o_oe_n, en}, 8'h00, "oc shutdown");
      repeat (10) @(posedge pclk);
      check(en, 6'h00, "restart hold");
      repeat (80) @(posedge pclk);
      check({o_oe_n, en}, {1'b1, exp_en(6'h19)}, "oc resume");
    end
    apb(1'b0, EVENTS_OFS, 32'h0);
    check(rd, 32'h2, "oc event");
    complete_run();
  end
endmodule

bind half_bridge_logic half_bridge_logic_props half_bridge_logic_props_inst (.*);
